/* logic/tsop_port.v */
// Transport stream output port with event request line
//
// Behaviour
// [RL1] Event request goes low while any enabled event is pending.
// [RL2] Request returns high only after every pending status register was read.
// [RL3] Byte clock output completes one cycle, falling then rising, per output byte slot.
// [RL4] Packet bytes appear whole on the eight-bit output bus.
// [RL5] Float input high tri-states data and clock; low drives them.
// [RL6] Byte valid is high exactly in slots carrying a real byte.
// [RL7] Packet start is high only on the first byte of a packet.
// [RL8] Fail output shows uncorrectable block or signal loss, by select bit.
// [RL9] External byte clock used only when both mode bits are set.
// [RL10] Fail select sits in bit 7 of monitor control, reset zero.
// [RL11] Stream data, flag and fail outputs change on the falling byte clock edge only.
`timescale 1ns/1ps
`default_nettype none
`include "tsop_consts.vh"

module tsop_port #(
   parameter       NUM_STAT = 4,
   parameter [7:0] DIV      = `TSOP_DIV_DEFAULT
) (
   input  wire                i_clk,
   input  wire                i_reset_n,
   input  wire [7:0]          i_byte,
   input  wire                i_byte_valid,
   input  wire                i_byte_first,
   output reg                 o_byte_ready,
   input  wire                i_uncorrectable,
   input  wire                i_signal_lost,
   input  wire                i_cfg_wr,
   input  wire [7:0]          i_cfg_addr,
   input  wire [7:0]          i_cfg_data,
   input  wire [NUM_STAT-1:0] i_event,
   input  wire [NUM_STAT-1:0] i_event_enable,
   input  wire [NUM_STAT-1:0] i_stat_read,
   input  wire                i_ext_byte_clock_in,
   input  wire                i_output_float_ctl,
   output reg                 o_event_request_n,
   output reg                 o_event_request_n_oe,
   output reg [7:0]           o_packet_byte_bus,
   output reg                 o_packet_byte_bus_oe,
   output reg                 o_packet_byte_clock_out,
   output reg                 o_packet_byte_clock_out_oe,
   output reg                 o_byte_valid_flag,
   output reg                 o_packet_start_flag,
   output reg                 o_block_fail_n,
   output reg                 o_ctl_oe,
   output reg [7:0]           o_monitor_control_reg
);

   //------------------------------------------------------------
   // Configuration bits
   //------------------------------------------------------------
   reg       op_ext;
   reg       fec_ext;
   // Only the three addresses below are decoded; any other write is
   // ignored, so a stray address cannot disturb the stream.
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_monitor_control_reg <= `TSOP_MONITOR_CONTROL_REG_RESET; // [RL10]
         op_ext                <= 1'b0;
         fec_ext               <= 1'b0;
      end else if (i_cfg_wr) begin
         if (i_cfg_addr == `TSOP_MONITOR_CONTROL_REG_ADDR) begin
            o_monitor_control_reg <= i_cfg_data; // [RL10]
         end else if (i_cfg_addr == `TSOP_OP_CTRL_ADDR) begin
            op_ext <= i_cfg_data[`TSOP_EXT_CLK_BIT];
         end else if (i_cfg_addr == `TSOP_FEC_SETUP_ADDR) begin
            fec_ext <= i_cfg_data[`TSOP_EXT_CLK_BIT];
         end
      end
   end
   wire use_ext = op_ext & fec_ext; // [RL9]

   //------------------------------------------------------------
   // Event request
   //------------------------------------------------------------
   // Each status register holds its own pending bit; set wins, so an
   // event landing in the cycle of its read is never lost.
   reg [NUM_STAT-1:0] pending;
   reg [NUM_STAT-1:0] next_pending;
   reg [NUM_STAT-1:0] fresh;

   always @* begin
      fresh        = i_event & i_event_enable; // [RL1]
      next_pending = pending & ~i_stat_read;   // [RL2]
      next_pending = next_pending | fresh;
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         pending              <= {NUM_STAT{1'b0}};
         o_event_request_n    <= 1'b1;
         o_event_request_n_oe <= 1'b0;
      end else begin
         pending              <= next_pending;
         // Line stays low until the last pending bit is read away
         o_event_request_n    <= ~(|pending); // [RL1] [RL2]
         // Open drain: the pin is only ever driven low
         o_event_request_n_oe <= |pending;
      end
   end

   //------------------------------------------------------------
   // Divider terminal count
   //------------------------------------------------------------
   // One place decides the wrap point, for the tick and the counter
   function div_last;
      input [7:0] count;
      input [7:0] limit;
      begin
         div_last = (count == limit - 8'h01);
      end
   endfunction

   //------------------------------------------------------------
   // Byte clock source
   //------------------------------------------------------------
   // External clock is sampled, so it must stay below a quarter rate.
   // Two flops settle the pin; the third only remembers the last level.
   reg [2:0] ext_sync;
   reg [7:0] div_cnt;
   reg       int_tick;
   wire      div_wrap = div_last(div_cnt, DIV);
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         ext_sync <= 3'h0;
         div_cnt  <= 8'h00;
         int_tick <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[1:0], i_ext_byte_clock_in};
         int_tick <= div_wrap;
         div_cnt  <= div_wrap ? 8'h00 : div_cnt + 8'h01;
      end
   end
   wire ext_rise = ext_sync[1] & ~ext_sync[2];
   wire ext_fall = ~ext_sync[1] & ext_sync[2];

   // Half-period ticks: internal divider gives both phases alternately
   wire raw_tick = use_ext ? (o_packet_byte_clock_out ? ext_fall : ext_rise)
                           : int_tick; // [RL9]

   // A source change can bring two ticks on adjacent cycles; the guard
   // drops the second so no byte clock phase is ever one cycle long.
   reg  last_tick;
   wire tick = raw_tick & ~last_tick;
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         last_tick <= 1'b0;
      end else begin
         last_tick <= tick;
      end
   end

   //------------------------------------------------------------
   // Byte clock output
   //------------------------------------------------------------
   // Rising edge marks the middle of a slot, falling edge its start
   wire fall_now = tick & o_packet_byte_clock_out;
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_packet_byte_clock_out <= 1'b0;
      end else if (tick) begin
         o_packet_byte_clock_out <= ~o_packet_byte_clock_out; // [RL3]
      end
   end

   //------------------------------------------------------------
   // Output stage
   //------------------------------------------------------------
   // Every stream output is launched at the falling byte clock edge,
   // leaving half a slot of settling before the receiver samples.
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_packet_byte_bus   <= 8'h00;
         o_byte_valid_flag   <= 1'b0;
         o_packet_start_flag <= 1'b0;
         o_byte_ready        <= 1'b0;
      end else begin
         o_byte_ready <= 1'b0;
         if (fall_now) begin // [RL11]
            o_byte_ready        <= i_byte_valid;
            o_byte_valid_flag   <= i_byte_valid; // [RL6]
            o_packet_start_flag <= i_byte_valid & i_byte_first; // [RL7]
            // An empty slot leaves the bus at its last byte
            if (i_byte_valid) begin
               o_packet_byte_bus <= i_byte; // [RL4]
            end
         end
      end
   end

   //------------------------------------------------------------
   // Block failure indicator
   //------------------------------------------------------------
   // Cause is picked by the select bit and launched with the data, so
   // the receiver sees it aligned with the byte it belongs to.
   wire fail_cause = o_monitor_control_reg[`TSOP_FAIL_SEL_BIT] ?
                     i_signal_lost : i_uncorrectable; // [RL8]
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_block_fail_n <= 1'b1;
      end else if (fall_now) begin
         o_block_fail_n <= ~fail_cause; // [RL8] [RL11]
      end
   end

   //------------------------------------------------------------
   // Float control, synchronised
   //------------------------------------------------------------
   // Pins stay floated through reset until a settled level arrives;
   // the enable lags the float pin by three cycles.
   reg [1:0] float_sync;
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         float_sync                 <= 2'h3;
         o_packet_byte_bus_oe       <= 1'b0;
         o_packet_byte_clock_out_oe <= 1'b0;
         o_ctl_oe                   <= 1'b0;
      end else begin
         float_sync                 <= {float_sync[0], i_output_float_ctl};
         o_packet_byte_bus_oe       <= ~float_sync[1]; // [RL5]
         o_packet_byte_clock_out_oe <= ~float_sync[1]; // [RL5]
         o_ctl_oe                   <= ~float_sync[1]; // [RL5]
      end
   end

endmodule // tsop_port
`default_nettype wire

/* logic/tsop_consts.vh */
// Constants for the transport stream output port
`ifndef TSOP_CONSTS_VH
`define TSOP_CONSTS_VH
`define TSOP_PKT_LEN         8'hbc
`define TSOP_DIV_DEFAULT     8'h10
`define TSOP_FAIL_SEL_BIT    7
`define TSOP_MONITOR_CONTROL_REG_ADDR   8'h67
`define TSOP_MONITOR_CONTROL_REG_RESET  8'h00
`define TSOP_OP_CTRL_ADDR    8'h60
`define TSOP_FEC_SETUP_ADDR  8'h61
`define TSOP_EXT_CLK_BIT     7
`endif

/* dv/tsop_port_asserts.sv */
// Port checker for the transport stream output port
`timescale 1ns/1ps
`default_nettype none
module tsop_port_asserts #(parameter NUM_STAT = 4) (
   input wire logic i_clk, i_reset_n, i_byte_first, i_cfg_wr,
   input wire logic i_output_float_ctl, o_byte_ready, o_event_request_n,
   input wire logic o_event_request_n_oe, o_packet_byte_bus_oe,
   input wire logic o_packet_byte_clock_out, o_byte_valid_flag,
   input wire logic o_packet_start_flag, o_block_fail_n,
   input wire logic i_uncorrectable, i_signal_lost,
   input wire logic [7:0] i_byte, i_cfg_addr, i_cfg_data,
   input wire logic [7:0] o_packet_byte_bus, o_monitor_control_reg,
   input wire logic [NUM_STAT-1:0] i_event, i_event_enable);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   property p_req; |(i_event & i_event_enable) |-> ##2 !o_event_request_n;
   endproperty
   a_req: assert property (p_req) else $error("request missed");
   property p_oe; o_event_request_n_oe == !o_event_request_n; endproperty
   a_oe: assert property (p_oe) else $error("request enable");
   property p_bus; o_byte_ready |->
      o_byte_valid_flag && o_packet_byte_bus == $past(i_byte); endproperty
   a_bus: assert property (p_bus) else $error("byte wrong");
   property p_st; o_byte_ready |-> o_packet_start_flag == $past(i_byte_first);
   endproperty
   a_st: assert property (p_st) else $error("start flag");
   property p_flt; i_output_float_ctl[*4] |-> !o_packet_byte_bus_oe;
   endproperty
   a_flt: assert property (p_flt) else $error("not floated");
   property p_drv; !i_output_float_ctl[*4] |-> o_packet_byte_bus_oe;
   endproperty
   a_drv: assert property (p_drv) else $error("not driven");
   property p_cfg; i_cfg_wr && i_cfg_addr == 8'h67 |=>
      o_monitor_control_reg[7] == $past(i_cfg_data[7]); endproperty
   a_cfg: assert property (p_cfg) else $error("select bit");
   property p_fail; o_byte_ready |-> o_block_fail_n ==
      !($past(o_monitor_control_reg[7]) ? $past(i_signal_lost)
                                        : $past(i_uncorrectable));
   endproperty
   a_fail: assert property (p_fail) else $error("fail source");
   // Byte clock phase shorter than two cycles would break the receiver's sampling
   property p_clk; $changed(o_packet_byte_clock_out) |=>
      $stable(o_packet_byte_clock_out); endproperty
   a_clk: assert property (p_clk) else $error("byte clock");
   c_pkt: cover property (o_byte_ready && o_packet_start_flag);
   c_req: cover property (!o_event_request_n);
   c_flt: cover property (!o_packet_byte_bus_oe);
endmodule // tsop_port_asserts
`default_nettype wire

/* dv/tsop_rx_model.sv */
// Receiving decoder model: runs the input clock, samples the stream
`timescale 1ns/1ps
`default_nettype none
module tsop_rx_model (
   input  wire logic       i_clk,
   input  wire logic       i_sclk,
   input  wire logic       i_valid,
   input  wire logic       i_first,
   input  wire logic [7:0] i_bus,
   output var  logic       o_ext_clk,
   output var  logic       o_got,
   output var  logic [8:0] o_word
);
   logic prev = 1'b0;
   initial begin
      o_ext_clk = 1'b0;
      forever #62.5 o_ext_clk = ~o_ext_clk; // Never paused
   end
   always @(posedge i_clk) begin
      prev   <= i_sclk;
      o_got  <= i_sclk && !prev && i_valid; // Rising edge
      o_word <= {i_first, i_bus};
   end
endmodule // tsop_rx_model
`default_nettype wire

/* dv/tsop_port_tb_top.sv */
// Top testbench for the transport stream output port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD %0t mismatch %h %h", $time, a, b); end end
module tsop_port_tb_top;
   logic clk = 0, rst_n = 0, vin = 0, fst = 0, wr = 0, fl = 0, unc, lost;
   logic [7:0] dat = 0, adr = 0, cd = 0;
   logic [3:0] ev = 0, en = 0, rd = 0;
   logic [8:0] exp_q[$];
   logic [31:0] seed = 32'd73795;
   wire rdy, rq_n, bus_oe, sclk, sclk_oe, vld, st, got, ext;
   wire rq_oe, fail_n, ctl_oe;
   wire [7:0] bus, mon;
   wire [8:0] w;
   int num_errors = 0, checks_done = 0;
   tsop_port #(.NUM_STAT(4), .DIV(8'h02)) i_dut (.i_clk(clk),
      .i_reset_n(rst_n), .i_byte(dat), .i_byte_valid(vin),
      .i_byte_first(fst), .o_byte_ready(rdy), .i_uncorrectable(unc),
      .i_signal_lost(lost), .i_cfg_wr(wr), .i_cfg_addr(adr),
      .i_cfg_data(cd), .i_event(ev), .i_event_enable(en), .i_stat_read(rd),
      .i_ext_byte_clock_in(ext), .i_output_float_ctl(fl),
      .o_event_request_n(rq_n), .o_event_request_n_oe(rq_oe),
      .o_packet_byte_bus(bus), .o_packet_byte_bus_oe(bus_oe),
      .o_packet_byte_clock_out(sclk), .o_packet_byte_clock_out_oe(sclk_oe),
      .o_byte_valid_flag(vld), .o_packet_start_flag(st),
      .o_block_fail_n(fail_n), .o_ctl_oe(ctl_oe),
      .o_monitor_control_reg(mon));
   tsop_rx_model u_rx (.i_clk(clk), .i_sclk(sclk & sclk_oe), .i_valid(vld),
      .i_first(st), .i_bus(bus_oe ? bus : ~bus), .o_ext_clk(ext),
      .o_got(got), .o_word(w));
   initial forever #2 clk = ~clk;
   task automatic tk(); @(posedge clk); #1; endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic cfg(input logic [7:0] a, d);
      {wr, adr, cd} = {1'b1, a, d}; tk(); wr = 0; tk();
   endtask
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         seed = xs(seed);
         {unc, lost, dat, fst, vin} = {seed[9:0], i % 4 == 0, 1'b1};
         exp_q.push_back({fst, dat});
         for (int k = 0; k < 200 && rdy !== 1'b1; k++) tk();
         tk();
      end
      vin = 0;
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) if (got === 1'b1) begin
      logic [8:0] e;
      e = exp_q.pop_front();
      `CHK(w, e)
   end
   initial begin #100000; num_errors++; close_out(); end
   initial begin
      {unc, lost} = 2'b00;
      repeat (6) tk();
      rst_n = 1;
      send(8);
      {ev, en} = {4'h3, 4'hf}; tk(); ev = 0; repeat (4) tk();
      `CHK(rq_n, 1'b0)
      `CHK(rq_oe, 1'b1)
      rd = 4'h1; tk(); rd = 0; repeat (4) tk();
      `CHK(rq_n, 1'b0)
      rd = 4'h2; tk(); rd = 0; repeat (4) tk();
      `CHK(rq_n, 1'b1)
      {unc, lost} = 2'b10;
      repeat (12) tk();
      `CHK(fail_n, 1'b0)
      cfg(8'h67, 8'h80); `CHK(mon[7], 1'b1)
      repeat (12) tk();
      `CHK(fail_n, 1'b1)
      lost = 1;
      repeat (12) tk();
      `CHK(fail_n, 1'b0)
      fl = 1; repeat (6) tk(); `CHK(bus_oe, 1'b0)
      `CHK(sclk_oe, 1'b0)
      `CHK(ctl_oe, 1'b0)
      fl = 0; repeat (6) tk(); `CHK(bus_oe, 1'b1)
      `CHK(sclk_oe, 1'b1)
      `CHK(ctl_oe, 1'b1)
      cfg(8'h60, 8'h80); cfg(8'h61, 8'h80); send(4);
      repeat (100) tk(); `CHK(exp_q.size(), 0)
      close_out();
   end
endmodule // tsop_port_tb_top
bind tsop_port tsop_port_asserts #(.NUM_STAT(NUM_STAT)) u_chk (.*);
`default_nettype wire
